// ---- rtl/kdw_pkg.sv ----
// Purpose: constants and carrier types for the keyed digital watchdog
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes:   reset cause flags live on the power-on reset only
package kdw_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_ENABLE   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRELOAD  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CAUSE    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_KEY      = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_COUNT    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;

  // enable word codes
  localparam logic [DATA_W-1:0] ENABLE_OFF_CODE = 32'h5312aced;
  localparam logic [DATA_W-1:0] ENABLE_ON_CODE  = 32'haced5312;
  localparam logic [DATA_W-1:0] ENABLE_RST      = 32'h00000000;

  // service key codes
  localparam int unsigned       KEY_W       = 16;
  localparam logic [KEY_W-1:0]  KEY_ARM     = 16'he51a;
  localparam logic [KEY_W-1:0]  KEY_SERVE   = 16'ha35c;
  localparam logic [KEY_W-1:0]  KEY_RST     = 16'ha35c;

  // preload and counter layout
  localparam int unsigned            PRELOAD_W     = 12;
  localparam logic [PRELOAD_W-1:0]   PRELOAD_RST   = 12'hfff;
  localparam int unsigned            COUNT_W       = 25;
  localparam int unsigned            COUNT_LOW_W   = 13;
  localparam logic [COUNT_LOW_W-1:0] COUNT_LOW_FILL = 13'h1fff;
  localparam logic [COUNT_W-1:0]     COUNT_RST     = 25'h0;

  // reset cause bit positions
  localparam int unsigned CAUSE_EXPIRY_BIT = 1;
  localparam int unsigned CAUSE_BADKEY_BIT = 2;

  // interrupt status and mask layout
  localparam int unsigned        IRQ_W         = 3;
  localparam int unsigned        IRQ_EXPIRY    = 0;
  localparam int unsigned        IRQ_BADKEY    = 1;
  localparam int unsigned        IRQ_SERVICE   = 2;
  localparam logic [IRQ_W-1:0]   IRQ_STAT_RST  = 3'h0;
  localparam logic [IRQ_W-1:0]   IRQ_MASK_RST  = 3'h0;

  typedef enum logic [0:0] {
    KDW_KEY_IDLE  = 1'b0,
    KDW_KEY_ARMED = 1'b1
  } kdw_key_e;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } kdw_bus_req_s;

  // reset-surviving cause flags
  typedef struct packed {
    logic badkey;
    logic expiry;
  } kdw_cause_s;

endpackage : kdw_pkg

// ---- rtl/kdw_cause_flags.sv ----
// Purpose: reset cause flags that outlive the module reset
// Assumes: por_b is the power-on reset, synchronous, active low
// Notes:   hardware set wins over a software clear in the same cycle
module kdw_cause_flags (
  // clock and power-on reset
  input  wire logic              clk_sys,
  input  wire logic              por_b,
  // set and clear requests
  input  wire logic              set_expiry,
  input  wire logic              set_badkey,
  input  wire logic              clr_expiry,
  input  wire logic              clr_badkey,
  // flag state
  output kdw_pkg::kdw_cause_s    flags
);
  import kdw_pkg::*;

  kdw_cause_s st_reg;
  kdw_cause_s st_next;

  always_comb begin
    st_next = st_reg;
    if (clr_expiry) begin
      st_next.expiry = 1'b0;
    end
    if (clr_badkey) begin
      st_next.badkey = 1'b0;
    end
    if (set_expiry) begin
      st_next.expiry = 1'b1;
    end
    if (set_badkey) begin
      st_next.badkey = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!por_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flags = st_reg;

endmodule : kdw_cause_flags

// ---- rtl/kdw_top.sv ----
// Purpose: keyed digital watchdog with write-once enable and service key
// Assumes: single 200 MHz clock; register port with read data one cycle late
// Notes:   sys_rst_req holds until the module reset arrives
//
// The placing of the registers and the plain strobed port were left to the implementer.
module kdw_top (
  // clock and resets
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  input  wire logic                   por_b,
  // register port
  input  kdw_pkg::kdw_bus_req_s       bus_req,
  output logic [kdw_pkg::DATA_W-1:0]  rd_data,
  // system outputs
  output logic                        sys_rst_req,
  output logic                        irq
);
  import kdw_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0]    enable_word;
    logic                 enable_written;
    logic                 running;
    logic [COUNT_W-1:0]   count;
    kdw_key_e             key;
    logic [KEY_W-1:0]     key_last;
    logic [PRELOAD_W-1:0] preload;
    logic [IRQ_W-1:0]     irq_stat;
    logic [IRQ_W-1:0]     irq_mask;
    logic [DATA_W-1:0]    rd_data;
    logic                 sys_rst_req;
    logic                 irq;
  } kdw_top_s;

  localparam kdw_top_s TOP_RST = '{
    enable_word:    ENABLE_RST,
    enable_written: 1'b0,
    running:        1'b0,
    count:          COUNT_RST,
    key:            KDW_KEY_IDLE,
    key_last:       KEY_RST,
    preload:        PRELOAD_RST,
    irq_stat:       IRQ_STAT_RST,
    irq_mask:       IRQ_MASK_RST,
    rd_data:        32'h00000000,
    sys_rst_req:    1'b0,
    irq:            1'b0
  };

  kdw_top_s   st_reg;
  kdw_top_s   st_next;
  kdw_cause_s cause;

  // decoded write strobes
  logic             wr_enable;
  logic             wr_preload;
  logic             wr_cause;
  logic             wr_key;
  logic             wr_irq_stat;
  logic             wr_irq_mask;
  logic [KEY_W-1:0] key_val;

  // events of this cycle
  logic             ev_expiry;
  logic             ev_badkey;
  logic             ev_service;
  logic [IRQ_W-1:0] ev_vec;

  // counter load value
  logic [COUNT_W-1:0] load_val;

  always_comb begin
    wr_enable   = bus_req.wr && (bus_req.addr == OFS_ENABLE);
    wr_preload  = bus_req.wr && (bus_req.addr == OFS_PRELOAD);
    wr_cause    = bus_req.wr && (bus_req.addr == OFS_CAUSE);
    wr_key      = bus_req.wr && (bus_req.addr == OFS_KEY);
    wr_irq_stat = bus_req.wr && (bus_req.addr == OFS_IRQ_STAT);
    wr_irq_mask = bus_req.wr && (bus_req.addr == OFS_IRQ_MASK);
    key_val     = bus_req.wdata[KEY_W-1:0];
  end

  always_comb begin
    load_val = {st_reg.preload, COUNT_LOW_FILL};
  end

  always_comb begin
    st_next    = st_reg;
    ev_expiry  = 1'b0;
    ev_badkey  = 1'b0;
    ev_service = 1'b0;

    if (st_reg.running) begin
      if (st_reg.count == COUNT_RST) begin
        ev_expiry       = 1'b1;
        st_next.running = 1'b0;
      end else begin
        st_next.count = st_reg.count - 25'h1;
      end
    end

    if (wr_enable && !st_reg.enable_written) begin
      st_next.enable_word    = bus_req.wdata;
      st_next.enable_written = 1'b1;
      if (bus_req.wdata != ENABLE_OFF_CODE) begin
        st_next.running = 1'b1;
        st_next.count   = load_val;
      end
    end

    if (wr_preload) begin
      st_next.preload = bus_req.wdata[PRELOAD_W-1:0];
    end

    // key sequencing
    if (wr_key) begin
      st_next.key_last = key_val;
      if (key_val == KEY_ARM) begin
        st_next.key = KDW_KEY_ARMED;
      end else if (key_val == KEY_SERVE) begin
        if (st_reg.key == KDW_KEY_ARMED) begin
          st_next.key = KDW_KEY_IDLE;
          ev_service  = 1'b1;
          if (st_next.running) begin
            st_next.count = load_val;
          end
        end
      end else begin
        ev_badkey   = 1'b1;
        st_next.key = KDW_KEY_IDLE;
      end
    end

    // held until the module reset takes it down
    if (ev_expiry || ev_badkey) begin
      st_next.sys_rst_req = 1'b1;
    end

    // interrupt status: set wins over write-one clear
    ev_vec = {ev_service, ev_badkey, ev_expiry};
    if (wr_irq_stat) begin
      st_next.irq_stat = st_reg.irq_stat & ~bus_req.wdata[IRQ_W-1:0];
    end
    st_next.irq_stat = st_next.irq_stat | ev_vec;
    if (wr_irq_mask) begin
      st_next.irq_mask = bus_req.wdata[IRQ_W-1:0];
    end
    st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

    // read data stands one cycle after the strobe only
    st_next.rd_data = 32'h00000000;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        OFS_ENABLE: begin
          st_next.rd_data = st_reg.enable_word;
        end
        OFS_PRELOAD: begin
          st_next.rd_data = {20'h00000, st_reg.preload};
        end
        OFS_CAUSE: begin
          st_next.rd_data = 32'h00000000;
          st_next.rd_data[CAUSE_EXPIRY_BIT] = cause.expiry;
          st_next.rd_data[CAUSE_BADKEY_BIT] = cause.badkey;
        end
        OFS_KEY: begin
          st_next.rd_data = {16'h0000, st_reg.key_last};
        end
        OFS_COUNT: begin
          st_next.rd_data = {7'h00, st_reg.count};
        end
        OFS_IRQ_STAT: begin
          st_next.rd_data = {29'h0, st_reg.irq_stat};
        end
        OFS_IRQ_MASK: begin
          st_next.rd_data = {29'h0, st_reg.irq_mask};
        end
        default: begin
          st_next.rd_data = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_reg <= TOP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  kdw_cause_flags u_cause (
    .clk_sys    (clk_sys),
    .por_b      (por_b),
    .set_expiry (ev_expiry),
    .set_badkey (ev_badkey),
    .clr_expiry (wr_cause && bus_req.wdata[CAUSE_EXPIRY_BIT]),
    .clr_badkey (wr_cause && bus_req.wdata[CAUSE_BADKEY_BIT]),
    .flags      (cause)
  );

  assign rd_data     = st_reg.rd_data;
  assign sys_rst_req = st_reg.sys_rst_req;
  assign irq         = st_reg.irq;

endmodule : kdw_top

// ---- tb/kdw_assertions.sv ----
// Purpose: port checks for the keyed watchdog
// Assumes: one clock, synchronous active-low reset
// Notes:   cause flags read only after por_b
module kdw_checker (
  // clock and reset
  input wire logic                         clk_sys,
  input wire logic                         rst_b,
  // register port
  input wire kdw_pkg::kdw_bus_req_s        bus_req,
  input wire logic [kdw_pkg::DATA_W-1:0]   rd_data,
  // system outputs
  input wire logic                         sys_rst_req,
  input wire logic                         irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import kdw_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic        seen_reg;
  logic [31:0] first_reg;
  logic [31:0] exp_en;
  logic        rdc;
  logic        bad;
  assign rdc = bus_req.rd && bus_req.addr == OFS_CAUSE;
  assign bad = bus_req.wr && bus_req.addr == OFS_KEY && bus_req.wdata[15:0] != KEY_ARM
               && bus_req.wdata[15:0] != KEY_SERVE;
  assign exp_en = seen_reg ? first_reg : 32'h0;
  // first enable write since reset is the only one kept
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      seen_reg  <= 1'b0;
      first_reg <= 32'h0;
    end else if (bus_req.wr && bus_req.addr == OFS_ENABLE && !seen_reg) begin
      seen_reg  <= 1'b1;
      first_reg <= bus_req.wdata;
    end
  end
  chk_reset_quiet: assert property ($rose(rst_b) |-> rd_data == 32'h0 && !sys_rst_req && !irq)
    else $error("outputs not quiet after reset");
  chk_enable_once: assert property (bus_req.rd && bus_req.addr == OFS_ENABLE |=> rd_data == $past(exp_en))
    else $error("enable word not write once");
  chk_count_upper: assert property (bus_req.rd && bus_req.addr == OFS_COUNT |=> rd_data[31:25] == 7'h0)
    else $error("counter upper bits set");
  chk_key_upper: assert property (bus_req.rd && bus_req.addr == OFS_KEY |=> rd_data[31:16] == 16'h0)
    else $error("key upper half set");
  chk_cause_spare: assert property (rdc |=> rd_data[31:3] == 29'h0 && !rd_data[0])
    else $error("cause spare bits set");
  chk_badkey_req: assert property (bad |=> sys_rst_req)
    else $error("bad key gave no reset request");
  chk_req_hold: assert property (sys_rst_req |=> sys_rst_req)
    else $error("reset request dropped");
  chk_badkey_flag: assert property (bad ##[1:2] rdc |=> rd_data[2])
    else $error("bad key flag missing");
  cover property (bad);
  cover property (rdc ##1 rd_data[1]);
  cover property ($rose(irq));
endmodule : kdw_checker

bind kdw_top kdw_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req),
  .rd_data(rd_data), .sys_rst_req(sys_rst_req), .irq(irq));

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the keyed watchdog
// Assumes: read data stands in the cycle after the strobe
// Notes:   preload zero keeps the expiry run near 8k cycles
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import kdw_pkg::*;
  logic         clk_sys;
  logic         rst_b;
  logic         por_b;
  kdw_bus_req_s req;
  logic [31:0]  rd_data;
  logic         sys_rst_req;
  logic         irq;
  logic [31:0]  rnd;
  int           bad_count;
  int           cmp_count;
  int           n;
  int           m_en, m_seen, m_pre, m_cause;
  kdw_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .por_b(por_b), .bus_req(req),
    .rd_data(rd_data), .sys_rst_req(sys_rst_req), .irq(irq));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // idle cycle after each strobe so no signal is set twice per edge
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    req <= {w, r, a, d};
    @(posedge clk_sys);
    req <= '0;
    // read data stand only until the next edge, so take them mid-cycle
    @(negedge clk_sys);
    q = rd_data;
    @(posedge clk_sys);
  endtask : op
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    if (a == OFS_ENABLE && m_seen == 0) begin
      m_seen = 1;
      m_en = d;
    end
    if (a == OFS_PRELOAD) m_pre = int'(d[11:0]);
    if (a == OFS_CAUSE) m_cause = m_cause & ~int'(d[2:0]);
    op(1'b1, 1'b0, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    op(1'b0, 1'b1, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  task automatic rst(input int c);
    rst_b <= 1'b0;
    repeat (c) @(posedge clk_sys);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    m_seen = 0;
    m_en = 0;
    m_pre = int'(PRELOAD_RST);
    @(posedge clk_sys);
  endtask : rst
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  initial begin
    rst_b = 1'b0;
    por_b = 1'b0;
    req = '0;
    rnd = 32'hbb822bec;
    bad_count = 0;
    cmp_count = 0;
    m_cause = 0;
    rst(20);
    rd(OFS_ENABLE, 32'h0);
    rd(OFS_COUNT, 32'h0);
    rd(OFS_PRELOAD, m_pre);
    wr(OFS_ENABLE, ENABLE_OFF_CODE);
    wr(OFS_ENABLE, ENABLE_ON_CODE);
    wr(OFS_COUNT, 32'h1234);
    rd(OFS_ENABLE, m_en);
    rd(OFS_COUNT, 32'h0);
    rd(8'h40, 32'h0);
    $display("test disabled word done");
    rst(2);
    rnd = lfsr(rnd);
    wr(OFS_PRELOAD, rnd);
    rnd = lfsr(rnd);
    wr(OFS_ENABLE, {rnd[31:1], 1'b0});
    rd(OFS_COUNT, {m_pre[11:0], 13'h1fff} - 1);
    wr(OFS_KEY, {16'h0, KEY_SERVE});
    wr(OFS_KEY, {16'h0, KEY_ARM});
    wr(OFS_KEY, {16'hffff, KEY_ARM});
    wr(OFS_KEY, {16'h0, KEY_SERVE});
    rd(OFS_COUNT, {m_pre[11:0], 13'h1fff} - 1);
    wr(OFS_KEY, {16'h0, KEY_SERVE});
    chk({31'h0, sys_rst_req}, 32'h0);
    rd(OFS_IRQ_STAT, 32'h4);
    wr(OFS_IRQ_MASK, 32'h4);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_STAT, 32'h4);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    $display("test service done");
    rnd = lfsr(rnd);
    wr(OFS_KEY, {16'h0, rnd[15:1], 1'b1});
    m_cause = 4;
    chk({31'h0, sys_rst_req}, 32'h1);
    rd(OFS_CAUSE, m_cause);
    rst(2);
    chk({31'h0, sys_rst_req}, 32'h0);
    rd(OFS_CAUSE, m_cause);
    wr(OFS_CAUSE, 32'h4);
    rd(OFS_CAUSE, m_cause);
    $display("test bad key done");
    wr(OFS_PRELOAD, 32'h0);
    wr(OFS_ENABLE, ENABLE_ON_CODE);
    n = 0;
    // sample mid-cycle so the request is seen where it is settled
    while (sys_rst_req !== 1'b1 && n < 9000) begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    chk(n, m_pre * 8192 + 8192);
    m_cause = 2;
    rd(OFS_CAUSE, m_cause);
    wr(OFS_CAUSE, 32'h0);
    rd(OFS_CAUSE, m_cause);
    wr(OFS_CAUSE, 32'h2);
    rd(OFS_CAUSE, m_cause);
    $display("test expiry done");
    results();
  end
  // the expiry run dominates, so some 2.4 times its length is ample
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    results();
  end
endmodule : testbench
